// *** mmi_pkg.sv ***
// shared constants, memory map helpers and timing counts of the management serial link
// assumes a single 50 MHz system clock at both ends
package mmi_pkg;
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned SCL_MAX_HZ = 400_000;
	localparam int unsigned SCL_FAST_HZ = 1_000_000;
	localparam logic [6:0]  DEV_ADDR = 7'h50;
	localparam logic [7:0]  LOWER_FIRST = 8'h00;
	localparam logic [7:0]  LOWER_LAST = 8'h7F;
	localparam logic [7:0]  UPPER_FIRST = 8'h80;
	localparam logic [7:0]  UPPER_LAST = 8'hFF;
	localparam logic [7:0]  PAGE_SEL_ADDR = 8'h7F;
	localparam logic [7:0]  PTR_RESET = 8'h00;
	localparam int unsigned NV_BUSY_MS = 80;
	localparam int unsigned VOL_BUSY_MS = 10;
	localparam int unsigned PAGE_BUSY_MS = 10;
	localparam int unsigned READ_GAP_US = 20;
	localparam int unsigned SEL_SETUP_MS = 2;
	localparam int unsigned STRETCH_MAX_US = 500;
	localparam int unsigned DEV_STRETCH_NS = 1000;
	localparam int unsigned NV_BUSY_CYC_DFLT = NV_BUSY_MS * (SYS_CLK_HZ / 1000);
	localparam int unsigned VOL_BUSY_CYC_DFLT = VOL_BUSY_MS * (SYS_CLK_HZ / 1000);
	localparam int unsigned PAGE_BUSY_CYC_DFLT = PAGE_BUSY_MS * (SYS_CLK_HZ / 1000);
	localparam int unsigned READ_GAP_CYC = READ_GAP_US * (SYS_CLK_HZ / 1_000_000);
	// strictly more than the setup time, hence the extra cycle
	localparam int unsigned SEL_SETUP_CYC_DFLT = SEL_SETUP_MS * (SYS_CLK_HZ / 1000) + 1;
	localparam int unsigned STRETCH_MAX_CYC_DFLT = STRETCH_MAX_US * (SYS_CLK_HZ / 1_000_000);
	localparam int unsigned DEV_STRETCH_CYC = (DEV_STRETCH_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned BUSY_W = 23;

	typedef enum logic [1:0] {WK_NONE = 2'b00, WK_VOL = 2'b01, WK_PAGE = 2'b10,
		WK_NV = 2'b11} mmi_wkind_t;
	typedef enum logic [1:0] {OP_WRITE = 2'b00, OP_READ_AT = 2'b01, OP_READ_CUR = 2'b10,
		OP_POLL = 2'b11} mmi_op_t;

	function automatic logic [7:0] mmi_next_addr(input logic [7:0] a);
		if (a == LOWER_LAST)
			mmi_next_addr = LOWER_FIRST;
		else if (a == UPPER_LAST)
			mmi_next_addr = UPPER_FIRST;
		else
			mmi_next_addr = a + 8'h01;
	endfunction : mmi_next_addr

	// upper half is the non-volatile area, the rest of lower memory is volatile
	function automatic mmi_wkind_t mmi_wr_kind(input logic [7:0] a);
		if (a == PAGE_SEL_ADDR)
			mmi_wr_kind = WK_PAGE;
		else if (a >= UPPER_FIRST)
			mmi_wr_kind = WK_NV;
		else
			mmi_wr_kind = WK_VOL;
	endfunction : mmi_wr_kind
endpackage : mmi_pkg

// *** mmi_link_if.sv ***
// two-wire management link with module select, shared by host and target
// lines are open drain with a pull-up; each end drives low only
interface mmi_link_if;
	logic hostSclOut;
	logic hostSclOe_n;
	logic hostSdaOut;
	logic hostSdaOe_n;
	logic devSclOut;
	logic devSclOe_n;
	logic devSdaOut;
	logic devSdaOe_n;
	logic moduleSelectActiveLow;
	logic scl;
	logic sda;

	assign scl = (hostSclOe_n | hostSclOut) & (devSclOe_n | devSclOut);
	assign sda = (hostSdaOe_n | hostSdaOut) & (devSdaOe_n | devSdaOut);

	modport host (input scl, input sda, output hostSclOut, output hostSclOe_n,
		output hostSdaOut, output hostSdaOe_n, output moduleSelectActiveLow);
	modport target (input scl, input sda, input moduleSelectActiveLow,
		output devSclOut, output devSclOe_n, output devSdaOut, output devSdaOe_n);
endinterface : mmi_link_if

// *** mmi_target.sv ***
// management serial target of the module: 256-byte memory behind the two-wire link
// assumes link lines synchronous to clk_sys, host sending the clock and module select
module mmi_target
	import mmi_pkg::*;
#(
	parameter int unsigned NV_BUSY_CYC   = NV_BUSY_CYC_DFLT,
	parameter int unsigned VOL_BUSY_CYC  = VOL_BUSY_CYC_DFLT,
	parameter int unsigned PAGE_BUSY_CYC = PAGE_BUSY_CYC_DFLT
)
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	mmi_link_if.target      link,
	input  wire logic [7:0] peekAddr,
	output logic      [7:0] peekData,
	output logic            busy
);
	localparam int unsigned STR_W = $clog2(DEV_STRETCH_CYC + 1);

	typedef enum logic [2:0] {T_IDLE = 3'b000, T_RX = 3'b001, T_ACK = 3'b010,
		T_TX = 3'b011, T_HACK = 3'b100} mmi_tstate_t;
	typedef enum logic [1:0] {B_DEV = 2'b00, B_ADR = 2'b01, B_DATA = 2'b10} mmi_role_t;

	mmi_tstate_t       state_r;
	mmi_role_t         role_r;
	mmi_wkind_t        wrKind_r;
	logic [3:0]        bitCnt_r;
	logic [7:0]        shift_r;
	logic [7:0]        ptr_r;
	logic              rdMode_r;
	logic              hostAck_r;
	logic              sdaLow_r;
	logic              sclPrev_r;
	logic              sdaPrev_r;
	logic              didRead_r;
	logic [STR_W-1:0]  stretch_r;
	logic [BUSY_W-1:0] busyCnt_r;
	logic [BUSY_W-1:0] armCnt;
	logic [7:0]        mem_r [0:255];
	logic              selected;
	logic              sclRise;
	logic              sclFall;
	logic              startCond;
	logic              stopCond;
	logic              byteDone;
	logic              addrHit;
	logic              loadByte;
	logic              wrByte;
	logic              adrByte;
	logic [7:0]        memOut;
	mmi_wkind_t        kindNow;

	// oversampling at 50 MHz copes with any bus rate up to 1 MHz
	assign selected = !link.moduleSelectActiveLow;
	assign sclRise = link.scl & !sclPrev_r;
	assign sclFall = !link.scl & sclPrev_r;
	assign startCond = selected & link.scl & sclPrev_r & sdaPrev_r & !link.sda;
	assign stopCond = selected & link.scl & sclPrev_r & !sdaPrev_r & link.sda;
	assign byteDone = selected & (state_r == T_RX) & sclFall & (bitCnt_r == 4'h8);
	// a busy target stays silent on its address so that polling sees a nack
	assign addrHit = (shift_r[7:1] == DEV_ADDR) & (busyCnt_r == '0);
	assign loadByte = selected & sclFall & (((state_r == T_ACK) & rdMode_r) |
		((state_r == T_HACK) & hostAck_r));
	assign wrByte = byteDone & (role_r == B_DATA);
	assign adrByte = byteDone & (role_r == B_ADR);
	assign memOut = mem_r[ptr_r];
	assign kindNow = mmi_wr_kind(ptr_r);
	assign busy = (busyCnt_r != '0);
	// no power-mode input exists: timing and responses never depend on it
	assign armCnt = (wrKind_r == WK_NV)   ? BUSY_W'(NV_BUSY_CYC) :
		(wrKind_r == WK_PAGE) ? BUSY_W'(PAGE_BUSY_CYC) :
		(wrKind_r == WK_VOL)  ? BUSY_W'(VOL_BUSY_CYC) :
		didRead_r ? BUSY_W'(READ_GAP_CYC) : '0;

	assign link.devSclOut = 1'b0;
	assign link.devSdaOut = 1'b0;
	assign link.devSclOe_n = (stretch_r == '0);
	assign link.devSdaOe_n = !sdaLow_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
		end
		else
		begin
			sclPrev_r <= link.scl;
			sdaPrev_r <= link.sda;
		end
	end

	// releasing select drops any transfer at once, so nothing is acknowledged
	always_ff @(posedge clk_sys)
	begin
		if (rst || !selected)
		begin
			state_r <= T_IDLE;
			role_r <= B_DEV;
			bitCnt_r <= 4'h0;
			sdaLow_r <= 1'b0;
			rdMode_r <= 1'b0;
			hostAck_r <= 1'b0;
			shift_r <= 8'h00;
		end
		else if (startCond)
		begin
			state_r <= T_RX;
			role_r <= B_DEV;
			bitCnt_r <= 4'h0;
			sdaLow_r <= 1'b0;
		end
		else if (stopCond)
		begin
			state_r <= T_IDLE;
			sdaLow_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				T_IDLE:
				begin
					sdaLow_r <= 1'b0;
				end
				T_RX:
				begin
					if (sclRise)
					begin
						shift_r <= {shift_r[6:0], link.sda};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					else if (byteDone)
					begin
						bitCnt_r <= 4'h0;
						if (role_r != B_DEV || addrHit)
						begin
							sdaLow_r <= 1'b1;
							state_r <= T_ACK;
							if (role_r == B_DEV)
								rdMode_r <= shift_r[0];
						end
						else
							state_r <= T_IDLE;
					end
				end
				T_ACK:
				begin
					if (sclFall && rdMode_r)
					begin
						state_r <= T_TX;
						shift_r <= memOut;
						sdaLow_r <= !memOut[7];
					end
					else if (sclFall)
					begin
						state_r <= T_RX;
						sdaLow_r <= 1'b0;
						role_r <= (role_r == B_DEV) ? B_ADR : B_DATA;
					end
				end
				T_TX:
				begin
					if (sclRise)
						bitCnt_r <= bitCnt_r + 4'h1;
					else if (sclFall && bitCnt_r == 4'h8)
					begin
						state_r <= T_HACK;
						sdaLow_r <= 1'b0;
						bitCnt_r <= 4'h0;
					end
					else if (sclFall)
					begin
						shift_r <= {shift_r[6:0], 1'b0};
						sdaLow_r <= !shift_r[6];
					end
				end
				T_HACK:
				begin
					if (sclRise)
						hostAck_r <= !link.sda;
					else if (sclFall && hostAck_r)
					begin
						state_r <= T_TX;
						shift_r <= memOut;
						sdaLow_r <= !memOut[7];
					end
					else if (sclFall)
						state_r <= T_IDLE;
				end
				default:
					state_r <= T_IDLE;
			endcase
		end
	end

	// the pointer survives stop and deselect: it is the current address of the next read
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ptr_r <= PTR_RESET;
		else if (adrByte)
			ptr_r <= shift_r;
		else if (loadByte || wrByte)
			ptr_r <= mmi_next_addr(ptr_r);
	end

	always_ff @(posedge clk_sys)
	begin
		if (wrByte)
			mem_r[ptr_r] <= shift_r;
		peekData <= mem_r[peekAddr];
	end

	// busy time starts at the stop that closes the transaction
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			busyCnt_r <= '0;
			wrKind_r <= WK_NONE;
			didRead_r <= 1'b0;
		end
		else
		begin
			if (stopCond && armCnt != '0) // a nacked poll must not cut a running busy time
				busyCnt_r <= armCnt;
			else if (busyCnt_r != '0)
				busyCnt_r <= busyCnt_r - BUSY_W'(1);
			if (stopCond)
			begin
				wrKind_r <= WK_NONE;
				didRead_r <= 1'b0;
			end
			else
			begin
				if (wrByte && kindNow > wrKind_r)
					wrKind_r <= kindNow;
				if (loadByte)
					didRead_r <= 1'b1;
			end
		end
	end

	// short stretch before each read byte; far below the 500 us the host allows
	always_ff @(posedge clk_sys)
	begin
		if (rst || !selected)
			stretch_r <= '0;
		else if (loadByte)
			stretch_r <= STR_W'(DEV_STRETCH_CYC);
		else if (stretch_r != '0)
			stretch_r <= stretch_r - STR_W'(1);
	end
endmodule : mmi_target

// *** mmi_host.sv ***
// host controller end of the management link: runs one command at a time
// assumes a target on the link interface and a user holding commands until taken
module mmi_host
	import mmi_pkg::*;
#(
	parameter int unsigned SCL_HZ          = SCL_MAX_HZ,
	parameter int unsigned SEL_SETUP_CYC   = SEL_SETUP_CYC_DFLT,
	parameter int unsigned STRETCH_MAX_CYC = STRETCH_MAX_CYC_DFLT,
	parameter int unsigned NV_BUSY_CYC     = NV_BUSY_CYC_DFLT,
	parameter int unsigned VOL_BUSY_CYC    = VOL_BUSY_CYC_DFLT,
	parameter int unsigned PAGE_BUSY_CYC   = PAGE_BUSY_CYC_DFLT
)
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	mmi_link_if.host        link,
	input  wire logic       selectEnable,
	input  wire logic       cmdValid,
	output logic            cmdReady,
	input  wire mmi_op_t    cmdOp,
	input  wire logic [7:0] cmdAddr,
	input  wire logic [7:0] cmdLen,
	input  wire logic [7:0] wrData,
	output logic            wrTake,
	output logic            rdValid,
	output logic      [7:0] rdData,
	output logic            doneValid,
	output logic            doneAck,
	output logic            doneTimeout
);
	// quarter bit period rounded up so the bus never runs above SCL_HZ
	localparam int unsigned QTR_CYC = (SYS_CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

	typedef enum logic [2:0] {H_IDLE = 3'b000, H_SETUP = 3'b001, H_START = 3'b010,
		H_BYTE = 3'b011, H_STOP = 3'b100, H_GAP = 3'b101} mmi_hstate_t;
	typedef enum logic [2:0] {G_DEVW = 3'b000, G_ADR = 3'b001, G_DEVR = 3'b010,
		G_WDATA = 3'b011, G_RDATA = 3'b100} mmi_stage_t;

	mmi_hstate_t       state_r;
	mmi_stage_t        stage_r;
	mmi_op_t           op_r;
	mmi_wkind_t        wKind_r;
	logic [15:0]       div_r;
	logic [1:0]        q_r;
	logic [3:0]        bitCnt_r;
	logic [8:0]        shift_r;
	logic [8:0]        rx_r;
	logic [7:0]        len_r;
	logic [7:0]        addr_r;
	logic [BUSY_W-1:0] gap_r;
	logic [BUSY_W-1:0] gapNow;
	logic [31:0]       wait_r;
	logic [31:0]       sel_r;
	logic              sclLow_r;
	logic              sdaLow_r;
	logic              selOn_r;
	logic              ok_r;
	logic              qTick;
	logic              step;
	logic              stuck;
	logic              byteEnd;
	logic              ackOk;
	logic              lastByte;

	assign qTick = (div_r == 16'(QTR_CYC - 1));
	// phase 2 holds until the clock line really is high, which absorbs a stretch shorter than STRETCH_MAX_CYC
	assign step = qTick & ((q_r != 2'd2) | link.scl);
	assign stuck = (wait_r >= STRETCH_MAX_CYC);
	assign byteEnd = (state_r == H_BYTE) & step & (q_r == 2'd3) & (bitCnt_r == 4'h8);
	assign ackOk = !rx_r[0];
	assign lastByte = (len_r == 8'h01);
	assign cmdReady = (state_r == H_IDLE) & selectEnable & selOn_r;
	assign gapNow = !ok_r ? '0 :
		(wKind_r == WK_NV)   ? BUSY_W'(NV_BUSY_CYC) :
		(wKind_r == WK_PAGE) ? BUSY_W'(PAGE_BUSY_CYC) :
		(wKind_r == WK_VOL)  ? BUSY_W'(VOL_BUSY_CYC) :
		(op_r == OP_READ_AT || op_r == OP_READ_CUR) ? BUSY_W'(READ_GAP_CYC) : '0;

	assign link.hostSclOut = 1'b0;
	assign link.hostSdaOut = 1'b0;
	assign link.hostSclOe_n = !sclLow_r;
	assign link.hostSdaOe_n = !sdaLow_r;
	assign link.moduleSelectActiveLow = !selOn_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst || qTick)
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
	end

	// select may only drop between commands; setup time restarts on each assertion
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			selOn_r <= 1'b0;
		else if (state_r == H_IDLE)
			selOn_r <= selectEnable;
		if (rst || !selOn_r)
			sel_r <= '0;
		else if (sel_r < SEL_SETUP_CYC)
			sel_r <= sel_r + 32'd1;
		if (rst || !(q_r == 2'd2 && !link.scl && state_r inside {H_START, H_BYTE, H_STOP}))
			wait_r <= '0;
		else
			wait_r <= wait_r + 32'd1;
	end

	always_ff @(posedge clk_sys)
	begin
		wrTake <= 1'b0;
		rdValid <= 1'b0;
		doneValid <= 1'b0;
		if (rst)
		begin
			state_r <= H_IDLE;
			stage_r <= G_DEVW;
			op_r <= OP_POLL;
			wKind_r <= WK_NONE;
			q_r <= 2'd0;
			bitCnt_r <= 4'h0;
			shift_r <= 9'h1FF;
			rx_r <= 9'h1FF;
			len_r <= 8'h00;
			addr_r <= 8'h00;
			gap_r <= '0;
			sclLow_r <= 1'b0;
			sdaLow_r <= 1'b0;
			ok_r <= 1'b0;
			rdData <= 8'h00;
			doneAck <= 1'b0;
			doneTimeout <= 1'b0;
		end
		else if (stuck)
		begin
			state_r <= H_IDLE;
			sclLow_r <= 1'b0;
			sdaLow_r <= 1'b0;
			doneValid <= 1'b1;
			doneAck <= 1'b0;
			doneTimeout <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				H_IDLE:
				begin
					if (cmdValid && cmdReady)
					begin
						op_r <= cmdOp;
						len_r <= cmdLen;
						addr_r <= cmdAddr;
						wKind_r <= WK_NONE;
						ok_r <= 1'b0;
						stage_r <= (cmdOp == OP_READ_CUR) ? G_DEVR : G_DEVW;
						shift_r <= {DEV_ADDR, cmdOp == OP_READ_CUR, 1'b1};
						state_r <= H_SETUP;
					end
				end
				H_SETUP:
				begin
					if (sel_r >= SEL_SETUP_CYC && qTick)
					begin
						state_r <= H_START;
						q_r <= 2'd0;
					end
				end
				H_START:
				begin
					if (step)
					begin
						q_r <= q_r + 2'd1;
						unique case (q_r)
							2'd0: sdaLow_r <= 1'b0;
							2'd1: sclLow_r <= 1'b0;
							2'd2: sdaLow_r <= 1'b1;
							2'd3:
							begin
								sclLow_r <= 1'b1;
								state_r <= H_BYTE;
								bitCnt_r <= 4'h0;
							end
						endcase
					end
				end
				H_BYTE:
				begin
					if (step)
					begin
						q_r <= q_r + 2'd1;
						unique case (q_r)
							2'd0: sdaLow_r <= !shift_r[8];
							2'd1: sclLow_r <= 1'b0;
							2'd2: rx_r <= {rx_r[7:0], link.sda};
							2'd3:
							begin
								sclLow_r <= 1'b1;
								shift_r <= {shift_r[7:0], 1'b1};
								bitCnt_r <= bitCnt_r + 4'h1;
							end
						endcase
					end
					if (byteEnd)
					begin
						bitCnt_r <= 4'h0;
						if (stage_r == G_RDATA)
						begin
							rdValid <= 1'b1;
							rdData <= rx_r[8:1];
						end
						if (stage_r == G_WDATA)
						begin
							wKind_r <= (mmi_wr_kind(addr_r) > wKind_r) ? mmi_wr_kind(addr_r)
								: wKind_r;
							addr_r <= mmi_next_addr(addr_r);
						end
						// a nack on any host-sent byte ends the command as failed
						if (!ackOk && stage_r != G_RDATA)
							state_r <= H_STOP;
						else if ((stage_r == G_DEVW && op_r == OP_POLL) ||
							((stage_r == G_WDATA || stage_r == G_RDATA) && lastByte))
						begin
							ok_r <= 1'b1;
							state_r <= H_STOP;
						end
						else if (stage_r == G_DEVW)
						begin
							stage_r <= G_ADR;
							shift_r <= {addr_r, 1'b1};
						end
						else if (stage_r == G_ADR && op_r == OP_READ_AT)
						begin
							stage_r <= G_DEVR;
							shift_r <= {DEV_ADDR, 1'b1, 1'b1};
							state_r <= H_START;
						end
						else if (stage_r == G_ADR || stage_r == G_WDATA)
						begin
							if (stage_r == G_WDATA)
								len_r <= len_r - 8'h01;
							stage_r <= G_WDATA;
							shift_r <= {wrData, 1'b1};
							wrTake <= 1'b1;
						end
						else
						begin
							if (stage_r == G_RDATA)
								len_r <= len_r - 8'h01;
							stage_r <= G_RDATA;
							shift_r <= {8'hFF, (stage_r == G_RDATA) ? len_r == 8'h02 : lastByte};
						end
					end
				end
				H_STOP:
				begin
					if (step)
					begin
						q_r <= q_r + 2'd1;
						unique case (q_r)
							2'd0: sdaLow_r <= 1'b1;
							2'd1: sclLow_r <= 1'b0;
							2'd2: sdaLow_r <= 1'b0;
							2'd3:
							begin
								state_r <= H_GAP;
								gap_r <= gapNow;
								doneValid <= 1'b1;
								doneAck <= ok_r;
								doneTimeout <= 1'b0;
							end
						endcase
					end
				end
				H_GAP:
				begin
					if (gap_r == '0)
						state_r <= H_IDLE;
					else
						gap_r <= gap_r - BUSY_W'(1);
				end
				default:
					state_r <= H_IDLE;
			endcase
		end
	end
endmodule : mmi_host

// *** mmi_link_props.sv ***
// link checks between the host and target ends of the management link
// assumes link signals are sampled on clk_sys; rst is synchronous, active high
module mmi_link_props
#(
	parameter int unsigned SEL_SETUP_CYC   = 200,
	parameter int unsigned STRETCH_MAX_CYC = 300
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hostSclOe_n,
	input wire logic hostSdaOe_n,
	input wire logic devSclOe_n,
	input wire logic devSdaOe_n,
	input wire logic moduleSelectActiveLow,
	input wire logic scl,
	input wire logic sda
);
	logic [15:0] selCnt_r;
	logic [15:0] holdCnt_r;
	wire  [15:0] selCnt_nxt  = moduleSelectActiveLow ? 16'h0000 : selCnt_r + {15'h0000, ~&selCnt_r};
	wire  [15:0] holdCnt_nxt = devSclOe_n ? 16'h0000 : holdCnt_r + {15'h0000, ~&holdCnt_r};

	// both counters saturate so a long idle period cannot wrap them
	always_ff @(posedge clk_sys)
	begin
		selCnt_r  <= rst ? 16'h0000 : selCnt_nxt;
		holdCnt_r <= rst ? 16'h0000 : holdCnt_nxt;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_desel_quiet: assert property (moduleSelectActiveLow && $past(moduleSelectActiveLow)
		|-> devSdaOe_n && devSclOe_n) else $error("target drives a line while deselected");
	chk_dev_sda_edge: assert property ($changed(devSdaOe_n) |-> !scl)
		else $error("target changed data with clock high");
	chk_stretch_low: assert property ($fell(devSclOe_n) |-> !scl)
		else $error("target grabbed the clock while high");
	chk_stretch_bound: assert property (holdCnt_r < STRETCH_MAX_CYC)
		else $error("clock stretch too long");
	chk_sel_setup: assert property (scl && $fell(sda) |-> selCnt_r >= SEL_SETUP_CYC)
		else $error("start too soon after select");
	chk_start_host: assert property (scl && $fell(sda) |-> !hostSdaOe_n)
		else $error("start not made by host");
	chk_sel_bus_idle: assert property ($changed(moduleSelectActiveLow) |-> scl && sda)
		else $error("select changed on a busy bus");
	chk_sel_held: assert property (!moduleSelectActiveLow && !scl |=> !moduleSelectActiveLow)
		else $error("select dropped mid transfer");
endmodule : mmi_link_props

// *** module_mgmt_i2c_target_tb.sv ***
// bench: host and target joined on one link, plus a bench-driven second link
// into a second target for busy polling and deselect; one 50 MHz clock
module module_mgmt_i2c_target_tb import mmi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NV = 2000;
	localparam int VOL = 500;
	localparam int RD = READ_GAP_CYC;
	localparam int SETUP = 200;
	localparam int STR = 300;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       selectEnable = 1'b1;
	logic       cmdValid = 1'b0;
	mmi_op_t    cmdOp = OP_POLL;
	logic [7:0] cmdAddr = 8'h00;
	logic [7:0] cmdLen = 8'h01;
	logic [7:0] wrData = 8'h00;
	logic [7:0] rdData, peekData;
	logic [7:0] peekA = 8'h00;
	logic       cmdReady, wrTake, rdValid, doneValid, doneAck, doneTimeout, busy, busy2;
	logic       b2Scl = 1'b1;
	logic       b2Sda = 1'b1;
	logic       sel2 = 1'b0;
	int         error_cnt = 0;
	int         checked = 0;
	int         seed = 53526;
	logic [7:0] mdl [256];
	logic [7:0] ptr = 8'h00;
	mmi_link_if l1 ();
	mmi_link_if l2 ();
	assign l2.hostSclOut = 1'b0;
	assign l2.hostSdaOut = 1'b0;
	assign l2.hostSclOe_n = b2Scl;
	assign l2.hostSdaOe_n = b2Sda;
	assign l2.moduleSelectActiveLow = sel2;

	always #10 clk_sys = ~clk_sys;

	mmi_host #(.SCL_HZ(1_000_000), .SEL_SETUP_CYC(SETUP), .STRETCH_MAX_CYC(STR), .NV_BUSY_CYC(NV),
		.VOL_BUSY_CYC(VOL), .PAGE_BUSY_CYC(VOL)) i_mmi_host (.clk_sys(clk_sys), .rst(rst),
		.link(l1.host), .selectEnable(selectEnable), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .wrData(wrData), .wrTake(wrTake),
		.rdValid(rdValid), .rdData(rdData), .doneValid(doneValid), .doneAck(doneAck),
		.doneTimeout(doneTimeout));
	mmi_target #(.NV_BUSY_CYC(NV), .VOL_BUSY_CYC(VOL), .PAGE_BUSY_CYC(VOL)) i_mmi_target
		(.clk_sys(clk_sys), .rst(rst), .link(l1.target), .peekAddr(peekA),
		.peekData(peekData), .busy(busy));
	mmi_target #(.NV_BUSY_CYC(NV), .VOL_BUSY_CYC(VOL), .PAGE_BUSY_CYC(VOL)) i_mmi_target_b
		(.clk_sys(clk_sys), .rst(rst), .link(l2.target), .peekAddr(8'h00), .peekData(), .busy(busy2));
	mmi_link_props #(.SEL_SETUP_CYC(SETUP), .STRETCH_MAX_CYC(STR)) i_mmi_link_props
		(.clk_sys(clk_sys), .rst(rst), .hostSclOe_n(l1.hostSclOe_n), .hostSdaOe_n(l1.hostSdaOe_n),
		.devSclOe_n(l1.devSclOe_n), .devSdaOe_n(l1.devSdaOe_n), .scl(l1.scl), .sda(l1.sda),
		.moduleSelectActiveLow(l1.moduleSelectActiveLow));

	function automatic logic [7:0] nx(input logic [7:0] a);
		return (a == 8'h7F) ? 8'h00 : (a == 8'hFF) ? 8'h80 : a + 8'h01;
	endfunction : nx

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
			error_cnt++;
		end
	endtask : chk

	task automatic report_and_stop();
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic stall(input string nm);
		chk(nm, 1, 0);
		report_and_stop();
	endtask : stall

	// one host command; expectations come from the bench's own memory model
	task automatic do_cmd(input mmi_op_t op, input logic [7:0] a, input int n, input int gap);
		int k;
		int c;
		logic [7:0] p;
		k = 0;
		c = 0;
		p = (op == OP_READ_CUR) ? ptr : a;
		do
		begin
			@(negedge clk_sys);
			k++;
			if (k > 20000) stall("cmdReady");
		end
		while (cmdReady !== 1'b1);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		cmdOp <= op;
		cmdAddr <= a;
		cmdLen <= 8'(n);
		wrData <= 8'($random(seed));
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		k = 0;
		while (doneValid !== 1'b1)
		begin
			@(negedge clk_sys);
			k++;
			if (k > 30000) stall("doneValid");
			if (rdValid === 1'b1)
			begin
				chk("rdData", mdl[p], rdData);
				p = nx(p);
				c++;
			end
			if (wrTake === 1'b1)
			begin
				mdl[p] = wrData;
				p = nx(p);
				c++;
				@(posedge clk_sys);
				wrData <= 8'($random(seed));
			end
		end
		chk("doneAck", 1, doneAck);
		chk("doneTimeout", 0, doneTimeout);
		chk("byteCount", (op == OP_POLL) ? 0 : n, c);
		if (op != OP_POLL)
			ptr = p;
		if (gap > 0)
		begin
			chk("busyAtDone", 1, busy);
			k = 0;
			while (busy === 1'b1 && k < 5000)
			begin
				@(negedge clk_sys);
				k++;
			end
			chk("busyLen", 1, k <= gap && k + 150 >= gap);
		end
		if (op == OP_WRITE)
		begin
			@(posedge clk_sys);
			peekA <= a;
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("peekData", mdl[a], peekData);
		end
	endtask : do_cmd

	task automatic bb_bit(input logic b, output logic s);
		@(posedge clk_sys);
		b2Sda <= b;
		repeat (10) @(posedge clk_sys);
		b2Scl <= 1'b1;
		repeat (20) @(negedge clk_sys);
		s = l2.sda;
		@(posedge clk_sys);
		b2Scl <= 1'b0;
	endtask : bb_bit

	task automatic bb_start();
		@(posedge clk_sys);
		b2Sda <= 1'b1;
		repeat (10) @(posedge clk_sys);
		b2Scl <= 1'b1;
		repeat (20) @(posedge clk_sys);
		b2Sda <= 1'b0;
		repeat (20) @(posedge clk_sys);
		b2Scl <= 1'b0;
	endtask : bb_start

	task automatic bb_stop();
		@(posedge clk_sys);
		b2Sda <= 1'b0;
		repeat (10) @(posedge clk_sys);
		b2Scl <= 1'b1;
		repeat (20) @(posedge clk_sys);
		b2Sda <= 1'b1;
		repeat (20) @(posedge clk_sys);
	endtask : bb_stop

	task automatic bb_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bb_bit(b[i], s);
		bb_bit(1'b1, s);
		ack = ~s;
	endtask : bb_byte

	initial
	begin
		logic       a;
		logic [7:0] ra;
		int         k;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (300) @(posedge clk_sys);
		bb_start();
		bb_byte({DEV_ADDR, 1'b0}, a);
		bb_byte(8'h20, a);
		chk("ackAdr", 1, a);
		bb_byte(8'h5A, a);
		chk("ackData", 1, a);
		bb_stop();
		bb_start();
		bb_byte({DEV_ADDR, 1'b0}, a);
		bb_stop();
		chk("pollBusy", 0, a);
		chk("busy2", 1, busy2);
		repeat (VOL) @(posedge clk_sys);
		bb_start();
		bb_byte({DEV_ADDR, 1'b0}, a);
		bb_stop();
		chk("pollReady", 1, a);
		repeat (1100) @(posedge clk_sys);
		sel2 <= 1'b1;
		repeat (20) @(posedge clk_sys);
		bb_start();
		bb_byte({DEV_ADDR, 1'b0}, a);
		bb_stop();
		chk("deselAck", 0, a);
		do_cmd(OP_POLL, 8'h00, 1, 0);
		do_cmd(OP_WRITE, 8'h7E, 4, VOL);
		do_cmd(OP_READ_AT, 8'h7E, 4, RD);
		do_cmd(OP_WRITE, 8'hFE, 3, NV);
		do_cmd(OP_READ_AT, 8'hFE, 1, RD);
		do_cmd(OP_READ_CUR, 8'h00, 2, RD);
		do_cmd(OP_WRITE, 8'h10, 8, VOL);
		for (int i = 0; i < 6; i++)
		begin
			ra = 8'h10 + 8'($random(seed) & 32'h3);
			k = 1 + ($random(seed) & 32'h3);
			if ($random(seed) & 32'h1)
				do_cmd(OP_WRITE, ra, k, VOL);
			else
				do_cmd(OP_READ_AT, ra, k, RD);
		end
		do_cmd(OP_READ_CUR, 8'h00, 1, RD);
		@(posedge clk_sys);
		selectEnable <= 1'b0;
		k = 0;
		while (l1.moduleSelectActiveLow !== 1'b1)
		begin
			@(negedge clk_sys);
			k++;
			if (k > 100) stall("selectOff");
		end
		repeat (SETUP) @(posedge clk_sys);
		selectEnable <= 1'b1;
		do_cmd(OP_POLL, 8'h00, 1, 0);
		report_and_stop();
	end
endmodule : module_mgmt_i2c_target_tb
